// File: src/ecc_pkg.sv
package ecc_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_A_CTRL_ONE = 8'h00;
    localparam logic [7:0] ADDR_A_CTRL_TWO = 8'h01;
    localparam logic [7:0] ADDR_B_CTRL_ONE = 8'h20;
    localparam logic [7:0] ADDR_B_CTRL_TWO = 8'h21;
    localparam logic [7:0] ADDR_STATUS     = 8'h30;

    // Reset values
    localparam logic [7:0] CTRL_ONE_RESET  = 8'h02;
    localparam logic [7:0] CTRL_TWO_RESET  = 8'h00;
    localparam logic [7:0] RDATA_RESET     = 8'h00;

    // First control register fields
    localparam int BIT_BACK_TO_BACK  = 5;
    localparam int BIT_PAD           = 4;
    localparam int BIT_BYPASS        = 3;
    localparam int BIT_ADAPT_FREEZE  = 2;

    // Second control register fields
    localparam int BIT_TONE_OFF      = 7;
    localparam int BIT_PHASE_IGNORE  = 6;
    localparam int BIT_NLP_OFF       = 5;
    localparam int BIT_AUTO_TONE     = 4;
    localparam int BIT_NARROWBAND    = 3;
    localparam int BIT_OFFSET_FILTER = 2;
    localparam int BIT_SEND_SILENCE  = 1;
    localparam int BIT_RECV_SILENCE  = 0;

    // Status register fields
    localparam int BIT_ST_TONE_PD    = 4;
    localparam int BIT_ST_CLEAR_B    = 3;
    localparam int BIT_ST_CLEAR_A    = 2;
    localparam int BIT_ST_ADAPT_B    = 1;
    localparam int BIT_ST_ADAPT_A    = 0;

    // 12 dB is taken as a gain of one quarter (12.04 dB), i.e. two arithmetic shifts
    localparam int ATTEN_SHIFT       = 2;

    typedef struct packed {
        logic adapt_en;
        logic coef_clr;
        logic hpf_off;
        logic nlp_off;
        logic ph_ign;
        logic nb_off;
        logic tone_auto;
        logic b2b_sel;
        logic bypass;
        logic pad;
        logic send_quiet;
        logic recv_quiet;
    } ecc_chan_type;

    function automatic ecc_chan_type ecc_decode(input logic [7:0] c1, input logic [7:0] c2);
        ecc_chan_type d;
        d.bypass   = c1[BIT_BYPASS];
        d.pad      = c1[BIT_PAD];
        d.b2b_sel  = c1[BIT_BACK_TO_BACK];
        d.coef_clr = c1[BIT_BYPASS];
        d.adapt_en = !c1[BIT_BYPASS] && !c1[BIT_ADAPT_FREEZE];
        d.hpf_off  = c2[BIT_OFFSET_FILTER];
        d.nlp_off  = c2[BIT_NLP_OFF];
        d.ph_ign   = c2[BIT_PHASE_IGNORE];
        d.nb_off   = c2[BIT_NARROWBAND];
        d.tone_auto  = c2[BIT_AUTO_TONE];
        d.send_quiet = c2[BIT_SEND_SILENCE];
        d.recv_quiet = c2[BIT_RECV_SILENCE];
        return d;
    endfunction : ecc_decode

endpackage : ecc_pkg

// File: src/ecc_chan_if.sv
`timescale 1ns/10ps
`default_nettype none

interface ecc_chan_if;
    logic bypass;
    logic pad;
    logic send_mute;
    logic recv_mute;

    modport ctrl (
        output bypass,
        output pad,
        output send_mute,
        output recv_mute
    );

    modport path (
        input bypass,
        input pad,
        input send_mute,
        input recv_mute
    );
endinterface : ecc_chan_if

`default_nettype wire

// File: src/ecc_path.sv
`timescale 1ns/10ps
`default_nettype none

module ecc_path #(
    parameter int          W     = 16,
    parameter logic [W-1:0] QUIET = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    ecc_chan_if.path          ctl,
    input  wire logic [W-1:0] rin,
    input  wire logic [W-1:0] sin,
    input  wire logic [W-1:0] algo_sout,
    input  wire logic [W-1:0] algo_rout,
    output logic      [W-1:0] sout,
    output logic      [W-1:0] rout
);

    typedef struct packed {
        logic [W-1:0] sout;
        logic [W-1:0] rout;
    } ecc_path_state_type;

    ecc_path_state_type st_reg;
    ecc_path_state_type st_next;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        // Mute sits last in the path so it also silences bypassed data
        if (ctl.send_mute) begin
            st_next.sout = QUIET;
        end else if (ctl.bypass) begin
            st_next.sout = sin;
        end else begin
            st_next.sout = algo_sout;
        end
        if (ctl.recv_mute) begin
            st_next.rout = QUIET;
        end else if (ctl.bypass) begin
            st_next.rout = rin;
        end else if (ctl.pad) begin
            st_next.rout = W'($signed(algo_rout) >>> ecc_pkg::ATTEN_SHIFT);
        end else begin
            st_next.rout = algo_rout;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sout = st_reg.sout;
    assign rout = st_reg.rout;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    send_bypass_a: assert property (ctl.bypass && !ctl.send_mute |=> sout == $past(sin))
        else $error("send bypass did not pass input");
    recv_bypass_a: assert property (ctl.bypass && !ctl.recv_mute |=> rout == $past(rin))
        else $error("receive bypass did not pass input");
    send_mute_a: assert property (ctl.send_mute |=> sout == QUIET)
        else $error("send output not quiet while muted");
    recv_mute_a: assert property (ctl.recv_mute |=> rout == QUIET)
        else $error("receive output not quiet while muted");
    pad_atten_a: assert property (!ctl.bypass && ctl.pad && !ctl.recv_mute
        |=> rout == W'($signed($past(algo_rout)) >>> ecc_pkg::ATTEN_SHIFT))
        else $error("receive attenuation not applied");
    algo_path_a: assert property (!ctl.bypass && !ctl.pad && !ctl.recv_mute && !ctl.send_mute
        |=> rout == $past(algo_rout) && sout == $past(algo_sout))
        else $error("outputs not taken from algorithm");

endmodule : ecc_path

`default_nettype wire

// File: src/ecc_top.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module ecc_top #(
    parameter int           W     = 16,
    parameter logic [W-1:0] QUIET = '0
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic [1:0][W-1:0] rin_pcm,
    input  wire logic [1:0][W-1:0] sin_pcm,
    input  wire logic [1:0][W-1:0] algo_sout,
    input  wire logic [1:0][W-1:0] algo_rout,
    output logic      [1:0][W-1:0] sout_pcm,
    output logic      [1:0][W-1:0] rout_pcm,
    output logic      [1:0]        adapt_enable,
    output logic      [1:0]        coef_clear,
    output logic      [1:0]        offset_filter_off,
    output logic      [1:0]        nonlinear_proc_off,
    output logic      [1:0]        phase_reversal_ignore,
    output logic      [1:0]        narrowband_detector_off,
    output logic      [1:0]        automatic_tone_bypass,
    output logic      [1:0]        back_to_back_select,
    output logic                   tone_detector_powerdown
);

    typedef struct packed {
        logic [7:0]                 a_one;
        logic [7:0]                 a_two;
        logic [7:0]                 b_one;
        logic [7:0]                 b_two;
        logic [7:0]                 rdata;
        ecc_pkg::ecc_chan_type [1:0] chan;
        logic                       tone_pd;
    } ecc_state_type;

    ecc_state_type st_reg;
    ecc_state_type st_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Register access

    function automatic logic [7:0] ecc_read(input ecc_state_type s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ecc_pkg::ADDR_A_CTRL_ONE: v = s.a_one;
            ecc_pkg::ADDR_A_CTRL_TWO: v = s.a_two;
            ecc_pkg::ADDR_B_CTRL_ONE: v = s.b_one;
            ecc_pkg::ADDR_B_CTRL_TWO: v = s.b_two;
            ecc_pkg::ADDR_STATUS: begin
                v[ecc_pkg::BIT_ST_TONE_PD] = s.tone_pd;
                v[ecc_pkg::BIT_ST_CLEAR_B] = s.chan[1].coef_clr;
                v[ecc_pkg::BIT_ST_CLEAR_A] = s.chan[0].coef_clr;
                v[ecc_pkg::BIT_ST_ADAPT_B] = s.chan[1].adapt_en;
                v[ecc_pkg::BIT_ST_ADAPT_A] = s.chan[0].adapt_en;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction : ecc_read

    always_comb begin
        st_next = st_reg;
        // Read data stands for one cycle only; zero otherwise
        st_next.rdata = reg_rd ? ecc_read(st_reg, reg_addr) : ecc_pkg::RDATA_RESET;
        // Reserved bits are stored as written; correct values are software's job
        if (reg_wr) begin
            case (reg_addr)
                ecc_pkg::ADDR_A_CTRL_ONE: st_next.a_one = reg_wdata;
                ecc_pkg::ADDR_A_CTRL_TWO: st_next.a_two = reg_wdata;
                ecc_pkg::ADDR_B_CTRL_ONE: st_next.b_one = reg_wdata;
                ecc_pkg::ADDR_B_CTRL_TWO: st_next.b_two = reg_wdata;
                default: st_next.a_one = st_reg.a_one;
            endcase
        end
        // Per-canceller controls, one cycle behind the registers
        st_next.chan[0] = ecc_pkg::ecc_decode(st_reg.a_one, st_reg.a_two);
        st_next.chan[1] = ecc_pkg::ecc_decode(st_reg.b_one, st_reg.b_two);
        // One canceller alone cannot shut the shared tone processors down
        st_next.tone_pd = st_reg.a_two[ecc_pkg::BIT_TONE_OFF]
                       && st_reg.b_two[ecc_pkg::BIT_TONE_OFF];
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg       <= '0;
            st_reg.a_one <= ecc_pkg::CTRL_ONE_RESET;
            st_reg.b_one <= ecc_pkg::CTRL_ONE_RESET;
            st_reg.a_two <= ecc_pkg::CTRL_TWO_RESET;
            st_reg.b_two <= ecc_pkg::CTRL_TWO_RESET;
            st_reg.rdata <= ecc_pkg::RDATA_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata               = st_reg.rdata;
    assign tone_detector_powerdown = st_reg.tone_pd;

    for (genvar i = 0; i < 2; i++) begin : g_chan
        ecc_chan_if chan_if ();

        assign chan_if.bypass    = st_reg.chan[i].bypass;
        assign chan_if.pad       = st_reg.chan[i].pad;
        assign chan_if.send_mute = st_reg.chan[i].send_quiet;
        assign chan_if.recv_mute = st_reg.chan[i].recv_quiet;

        assign adapt_enable[i]            = st_reg.chan[i].adapt_en;
        assign coef_clear[i]              = st_reg.chan[i].coef_clr;
        assign offset_filter_off[i]       = st_reg.chan[i].hpf_off;
        assign nonlinear_proc_off[i]      = st_reg.chan[i].nlp_off;
        assign phase_reversal_ignore[i]   = st_reg.chan[i].ph_ign;
        assign narrowband_detector_off[i] = st_reg.chan[i].nb_off;
        assign automatic_tone_bypass[i]   = st_reg.chan[i].tone_auto;
        assign back_to_back_select[i]     = st_reg.chan[i].b2b_sel;

        ecc_path #(
            .W     (W),
            .QUIET (QUIET)
        ) u_path (
            .ref_clk   (ref_clk),
            .sys_rst   (sys_rst),
            .ctl       (chan_if.path),
            .rin       (rin_pcm[i]),
            .sin       (sin_pcm[i]),
            .algo_sout (algo_sout[i]),
            .algo_rout (algo_rout[i]),
            .sout      (sout_pcm[i]),
            .rout      (rout_pcm[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    bypass_clears_a: assert property (st_reg.b_one[ecc_pkg::BIT_BYPASS]
        |=> coef_clear[1] && !adapt_enable[1])
        else $error("bypass did not clear and stop adaptation");
    freeze_holds_a: assert property (st_reg.a_one[ecc_pkg::BIT_ADAPT_FREEZE]
        && !st_reg.a_one[ecc_pkg::BIT_BYPASS] |=> !adapt_enable[0] && !coef_clear[0])
        else $error("freeze did not stop adaptation alone");
    adapt_runs_a: assert property (!st_reg.a_one[ecc_pkg::BIT_ADAPT_FREEZE]
        && !st_reg.a_one[ecc_pkg::BIT_BYPASS] |=> adapt_enable[0])
        else $error("adaptation not running");
    tone_down_a: assert property (st_reg.a_two[ecc_pkg::BIT_TONE_OFF]
        && st_reg.b_two[ecc_pkg::BIT_TONE_OFF] |=> tone_detector_powerdown)
        else $error("tone processors not powered down");
    tone_up_a: assert property (!(st_reg.a_two[ecc_pkg::BIT_TONE_OFF]
        && st_reg.b_two[ecc_pkg::BIT_TONE_OFF]) |=> !tone_detector_powerdown)
        else $error("tone processors powered down by one canceller");
    phase_follow_a: assert property (phase_reversal_ignore[1]
        == $past(st_reg.b_two[ecc_pkg::BIT_PHASE_IGNORE]))
        else $error("phase reversal control wrong");
    filter_follow_a: assert property (offset_filter_off[0]
        == $past(st_reg.a_two[ecc_pkg::BIT_OFFSET_FILTER]))
        else $error("offset filter control wrong");
    nlp_follow_a: assert property (nonlinear_proc_off[1]
        == $past(st_reg.b_two[ecc_pkg::BIT_NLP_OFF]))
        else $error("nonlinear processor control wrong");
    reg_write_a: assert property (reg_wr && reg_addr == ecc_pkg::ADDR_B_CTRL_TWO
        |=> st_reg.b_two == $past(reg_wdata))
        else $error("register write lost");
    reg_read_a: assert property (reg_rd && reg_addr == ecc_pkg::ADDR_A_CTRL_TWO
        |=> reg_rdata == $past(st_reg.a_two) ##1 reg_rdata == 8'h00 || $past(reg_rd))
        else $error("register read data wrong");

endmodule : ecc_top

`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam int           W     = 16;
    // Nonzero quiet code keeps muting distinct from cleared data
    localparam logic [W-1:0] QUIET = 16'h7F00;

    typedef struct {string name; int ch; logic [31:0] exp;} ecc_note_type;

    logic                   ref_clk;
    logic                   sys_rst;
    logic            [7:0]  reg_addr;
    logic            [7:0]  reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic            [7:0]  reg_rdata;
    logic                   rd_pend;
    logic      [1:0][W-1:0] rin_pcm;
    logic      [1:0][W-1:0] sin_pcm;
    logic      [1:0][W-1:0] algo_sout;
    logic      [1:0][W-1:0] algo_rout;
    logic      [1:0][W-1:0] sout_pcm;
    logic      [1:0][W-1:0] rout_pcm;
    logic            [1:0]  adapt_enable;
    logic            [1:0]  coef_clear;
    logic            [1:0]  offset_filter_off;
    logic            [1:0]  nonlinear_proc_off;
    logic            [1:0]  phase_reversal_ignore;
    logic            [1:0]  narrowband_detector_off;
    logic            [1:0]  automatic_tone_bypass;
    logic            [1:0]  back_to_back_select;
    logic                   tone_detector_powerdown;
    int                     fail_count;
    int                     tests_run;
    int                     cycles;
    logic            [7:0]  m1 [2];
    logic            [7:0]  m2 [2];
    ecc_note_type           rd_q [$];
    ecc_note_type           obs_q [$];
    event                   chk_ev;

    ecc_top #(.W(W), .QUIET(QUIET)) u_ecc_top (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rin_pcm(rin_pcm),
        .sin_pcm(sin_pcm), .algo_sout(algo_sout), .algo_rout(algo_rout), .sout_pcm(sout_pcm),
        .rout_pcm(rout_pcm), .adapt_enable(adapt_enable), .coef_clear(coef_clear),
        .offset_filter_off(offset_filter_off), .nonlinear_proc_off(nonlinear_proc_off),
        .phase_reversal_ignore(phase_reversal_ignore), .narrowband_detector_off(narrowband_detector_off),
        .automatic_tone_bypass(automatic_tone_bypass), .back_to_back_select(back_to_back_select),
        .tone_detector_powerdown(tone_detector_powerdown)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp(input string name, input int ch, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (exp !== seen) begin
            $display("MISMATCH %s ch%0d expected %h seen %h", name, ch, exp, seen);
            fail_count++;
        end
    endtask : cmp

    function automatic logic [31:0] observe(input string name, input int ch);
        case (name)
            "sout":  return 32'(sout_pcm[ch]);
            "rout":  return 32'(rout_pcm[ch]);
            "adapt": return 32'(adapt_enable[ch]);
            "clear": return 32'(coef_clear[ch]);
            "hpf":   return 32'(offset_filter_off[ch]);
            "nlp":   return 32'(nonlinear_proc_off[ch]);
            "phase": return 32'(phase_reversal_ignore[ch]);
            "nb":    return 32'(narrowband_detector_off[ch]);
            "auto":  return 32'(automatic_tone_bypass[ch]);
            "b2b":   return 32'(back_to_back_select[ch]);
            default: return 32'(tone_detector_powerdown);
        endcase
    endfunction : observe

    task automatic note(input string name, input int ch, input logic [31:0] exp);
        obs_q.push_back('{name, ch, exp});
    endtask : note

    task automatic flush_obs();
        ecc_note_type n;
        while (obs_q.size() > 0) begin
            n = obs_q.pop_front();
            cmp(n.name, n.ch, n.exp, observe(n.name, n.ch));
        end
    endtask : flush_obs

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        rd_q.push_back('{"reg_rdata", int'(a), 32'(exp)});
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask : rd

    function automatic logic [7:0] status_exp();
        return {3'h0, m2[0][ecc_pkg::BIT_TONE_OFF] && m2[1][ecc_pkg::BIT_TONE_OFF], m1[1][ecc_pkg::BIT_BYPASS],
                m1[0][ecc_pkg::BIT_BYPASS], !m1[1][ecc_pkg::BIT_BYPASS] && !m1[1][ecc_pkg::BIT_ADAPT_FREEZE],
                !m1[0][ecc_pkg::BIT_BYPASS] && !m1[0][ecc_pkg::BIT_ADAPT_FREEZE]};
    endfunction : status_exp

    // Fresh samples held steady so the registered outputs can be judged
    task automatic pcm_check();
        logic [7:0]   c1;
        logic [7:0]   c2;
        logic [W-1:0] er;
        @(posedge ref_clk);
        for (int c = 0; c < 2; c++) begin
            rin_pcm[c]   <= W'($urandom());
            sin_pcm[c]   <= W'($urandom());
            algo_sout[c] <= W'($urandom());
            algo_rout[c] <= W'($urandom());
        end
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        for (int c = 0; c < 2; c++) begin
            c1 = m1[c];
            c2 = m2[c];
            // Attenuation acts on the processed receive data; bypass overrides it
            er = c1[ecc_pkg::BIT_PAD] ? W'($signed(algo_rout[c]) >>> ecc_pkg::ATTEN_SHIFT) : algo_rout[c];
            er = c1[ecc_pkg::BIT_BYPASS] ? rin_pcm[c] : er;
            note("sout", c, c2[ecc_pkg::BIT_SEND_SILENCE] ? QUIET
                 : c1[ecc_pkg::BIT_BYPASS] ? sin_pcm[c] : algo_sout[c]);
            note("rout", c, c2[ecc_pkg::BIT_RECV_SILENCE] ? QUIET : er);
            note("adapt", c, !c1[ecc_pkg::BIT_BYPASS] && !c1[ecc_pkg::BIT_ADAPT_FREEZE]);
            note("clear", c, c1[ecc_pkg::BIT_BYPASS]);
            note("hpf", c, c2[ecc_pkg::BIT_OFFSET_FILTER]);
            note("nlp", c, c2[ecc_pkg::BIT_NLP_OFF]);
            note("phase", c, c2[ecc_pkg::BIT_PHASE_IGNORE]);
            note("nb", c, c2[ecc_pkg::BIT_NARROWBAND]);
            note("auto", c, c2[ecc_pkg::BIT_AUTO_TONE]);
            note("b2b", c, c1[ecc_pkg::BIT_BACK_TO_BACK]);
        end
        note("tpd", 0, m2[0][ecc_pkg::BIT_TONE_OFF] && m2[1][ecc_pkg::BIT_TONE_OFF]);
        ->chk_ev;
    endtask : pcm_check

    task automatic reset_and_check();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        m1 = '{ecc_pkg::CTRL_ONE_RESET, ecc_pkg::CTRL_ONE_RESET};
        m2 = '{ecc_pkg::CTRL_TWO_RESET, ecc_pkg::CTRL_TWO_RESET};
        rd(ecc_pkg::ADDR_A_CTRL_ONE, ecc_pkg::CTRL_ONE_RESET);
        rd(ecc_pkg::ADDR_A_CTRL_TWO, ecc_pkg::CTRL_TWO_RESET);
        rd(ecc_pkg::ADDR_B_CTRL_ONE, ecc_pkg::CTRL_ONE_RESET);
        rd(ecc_pkg::ADDR_B_CTRL_TWO, ecc_pkg::CTRL_TWO_RESET);
        pcm_check();
        rd(ecc_pkg::ADDR_STATUS, status_exp());
    endtask : reset_and_check

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        rd_pend <= reg_rd;
        cycles  <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    always @(negedge ref_clk) begin
        if (rd_pend === 1'b1 && rd_q.size() > 0) begin
            cmp(rd_q[0].name, rd_q[0].ch, rd_q[0].exp, 32'(reg_rdata));
            void'(rd_q.pop_front());
        end
    end

    always @(chk_ev) flush_obs();

    initial begin
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] dir [6] = '{8'h08, 8'h10, 8'h04, 8'h18, 8'h0C, 8'h20};
        int         ch;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd_pend = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        rin_pcm = '0;
        sin_pcm = '0;
        algo_sout = '0;
        algo_rout = '0;
        fail_count = 0;
        tests_run = 0;
        cycles = 0;
        void'($urandom(32'h7C38B75F));
        reset_and_check();
        for (int i = 0; i < 40; i++) begin
            ch = i % 2;
            c1 = (i < 12) ? dir[i / 2] : 8'($urandom());
            // Upper bits stay clear, so extended delay never meets back-to-back
            c1 = (c1 & 8'h3C) | 8'h02;
            c2 = (i < 2) ? 8'hFF : 8'($urandom());
            wr(ch ? ecc_pkg::ADDR_B_CTRL_ONE : ecc_pkg::ADDR_A_CTRL_ONE, c1);
            wr(ch ? ecc_pkg::ADDR_B_CTRL_TWO : ecc_pkg::ADDR_A_CTRL_TWO, c2);
            m1[ch] = c1;
            m2[ch] = c2;
            rd(ch ? ecc_pkg::ADDR_B_CTRL_ONE : ecc_pkg::ADDR_A_CTRL_ONE, c1);
            rd(ch ? ecc_pkg::ADDR_B_CTRL_TWO : ecc_pkg::ADDR_A_CTRL_TWO, c2);
            pcm_check();
            rd(ecc_pkg::ADDR_STATUS, status_exp());
        end
        // Reset in mid-run must restore every control, not just the last one written
        reset_and_check();
        wr(8'h05, 8'hFF);
        wr(ecc_pkg::ADDR_STATUS, 8'hFF);
        rd(8'h05, 8'h00);
        rd(ecc_pkg::ADDR_STATUS, status_exp());
        rd(ecc_pkg::ADDR_A_CTRL_ONE, ecc_pkg::CTRL_ONE_RESET);
        repeat (3) @(posedge ref_clk);
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
